// >>> bench/pms_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pms_link_sva #(
  parameter int HALF_CYC = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic mgmt_clk,
  input wire logic ctl_data_o,
  input wire logic ctl_data_oe,
  input wire logic dev_data_o,
  input wire logic dev_data_oe
);
  localparam int SPAN_MIN = 34 * HALF_CYC - 6;
  localparam int SPAN_MAX = 34 * HALF_CYC + 6;
  logic [11:0] oe_cnt_reg;
  logic [11:0] oe_cnt_next;

  // Counts enabled clk_sys cycles of one device drive window
  assign oe_cnt_next = dev_data_oe ? oe_cnt_reg + {11'h000, clk_en} : 12'h000;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oe_cnt_reg <= 12'h000;
    end else begin
      oe_cnt_reg <= oe_cnt_next;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  // Frozen cycles stretch every timing, so attempts spanning them are dropped
  default disable iff (rst || !clk_en);

  chk_no_contention: assert property (!(dev_data_oe && ctl_data_oe))
    else $error("device and controller drive the data line together");
  chk_ta_float: assert property ($rose(dev_data_oe) |-> mgmt_clk && !$past(ctl_data_oe, 8))
    else $error("device drive starts without a floating turnaround bit");
  chk_ta_drive_low: assert property ($rose(dev_data_oe) |-> !dev_data_o [*8])
    else $error("second turnaround bit not driven low");
  chk_read_span: assert property ($fell(dev_data_oe) |-> oe_cnt_reg >= SPAN_MIN && oe_cnt_reg <= SPAN_MAX)
    else $error("device drive window is not seventeen bit times");
  chk_dev_data_settle: assert property (
    dev_data_oe && $past(dev_data_oe) && $changed(dev_data_o) |-> mgmt_clk && $past(mgmt_clk, 2))
    else $error("device data changes near a rising management clock edge");
  chk_mdc_high_half: assert property ($rose(mgmt_clk) |-> mgmt_clk [*8] ##3 !mgmt_clk)
    else $error("management clock high time wrong");
  chk_mdc_low_half: assert property ($fell(mgmt_clk) |-> !mgmt_clk [*8])
    else $error("management clock low time too short");
  chk_ctl_data_setup: assert property (
    ctl_data_oe && $past(ctl_data_oe) && $changed(ctl_data_o) |-> !mgmt_clk)
    else $error("controller data changes while management clock high");
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pms_pkg::*;
  localparam logic [15:0] ID_HI = 16'h1a2b;  // Arbitrary identifier value
  localparam logic [15:0] ID_LO = 16'h3c4d;  // Arbitrary identifier value
  localparam logic [4:0] EXIST[5] = '{5'h00, 5'h04, 5'h08, 5'h12, 5'h13};
  localparam logic [4:0] ABSENT[4] = '{5'h09, 5'h0f, 5'h14, 5'h1f};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [4:0] strap = 5'h00;
  logic skip_en;
  logic wr_strobe;
  logic [4:0] wr_addr;
  logic [15:0] wr_data;
  logic [15:0] rd_val;
  logic [15:0] exp_q[$];
  logic [20:0] wexp_q[$];
  int failures = 0;
  int checks = 0;
  logic freeze = 1'b0;
  event rd_done;
  pms_link_if link();

  always #2 clk_sys = ~clk_sys;

  pms_ctl #(.HALF_CYC(10)) pms_ctl_inst(.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .link(link.ctl));
  pms_dev #(.ID_HIGH(ID_HI), .ID_LOW(ID_LO)) pms_dev_inst(.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .link(link.dev), .phy_addr_strap(strap), .preamble_skip_enable(skip_en), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data));
  pms_link_sva #(.HALF_CYC(10)) pms_link_sva_inst(.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .mgmt_clk(link.mgmt_clk), .ctl_data_o(link.ctl_data_o), .ctl_data_oe(link.ctl_data_oe),
    .dev_data_o(link.dev_data_o), .dev_data_oe(link.dev_data_oe));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic bus_wait();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    bus_wait();
    rd = hrdata;
  endtask

  // One management frame, launched and polled through the controller registers
  task automatic mdio(input logic wr, input logic skip, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] d);
    logic [31:0] r;
    int n;
    ahb(1'b1, OFS_DATA, {16'h0, d}, r);
    ahb(1'b1, OFS_CMD, {14'h0, skip, wr, 3'h0, phy, 3'h0, ra}, r);
    repeat (2) @(posedge clk_sys);
    // Hold clk_en low mid-frame; both ends must pause and resume intact
    if (freeze) begin
      repeat (1000) @(posedge clk_sys);
      clk_en <= 1'b0;
      repeat (37) @(posedge clk_sys);
      clk_en <= 1'b1;
    end
    n = 0;
    do begin
      ahb(1'b0, OFS_STATUS, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 2000);
    if (r[0] !== 1'b0) begin
      failures++;
      print_verdict();
    end
    if (!wr) begin
      ahb(1'b0, OFS_DATA, 32'h0, r);
      rd_val = r[15:0];
      -> rd_done;
    end
  endtask

  task automatic rd_exp(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] e, input logic skip);
    exp_q.push_back(e);
    mdio(1'b0, skip, phy, ra, 16'h0);
  endtask

  task automatic wr_op(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d, input logic hit);
    if (hit) begin
      wexp_q.push_back({ra, d});
    end
    mdio(1'b1, 1'b0, phy, ra, d);
  endtask

  initial begin
    forever begin
      @(rd_done);
      chk("read data", {16'h0, exp_q.pop_front()}, {16'h0, rd_val});
    end
  end

  always @(posedge clk_sys) begin
    if (wr_strobe === 1'b1) begin
      chk("write strobe", (wexp_q.size() > 0) ? {11'h0, wexp_q.pop_front()} : 32'hffffffff,
          {11'h0, wr_addr, wr_data});
    end
  end

  initial begin
    logic [15:0] d;
    logic [4:0] p;
    logic [31:0] r;
    d = 16'($urandom(32'hb3ec7eab));
    strap <= 5'($urandom);
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    p = strap;
    for (int i = 0; i < 5; i++) begin
      d = 16'($urandom);
      wr_op(p, EXIST[i], d, 1'b1);
      rd_exp(p, EXIST[i], d, 1'b0);
    end
    $display("test 1 done");
    rd_exp(p, 5'h02, ID_HI, 1'b0);
    rd_exp(p, 5'h03, ID_LO, 1'b0);
    $display("test 2 done");
    for (int i = 0; i < 4; i++) begin
      wr_op(p, ABSENT[i], 16'($urandom), 1'b0);
      rd_exp(p, ABSENT[i], DATA_ABSENT, 1'b0);
    end
    $display("test 3 done");
    wr_op(p, 5'h04, 16'h1234, 1'b1);
    rd_exp(p ^ 5'h01, 5'h04, 16'hffff, 1'b0);
    wr_op(p ^ 5'h01, 5'h04, 16'h5a5a, 1'b0);
    rd_exp(p, 5'h04, 16'h1234, 1'b0);
    $display("test 4 done");
    wr_op(p, 5'h01, 16'h0040, 1'b1);
    rd_exp(p, 5'h01, 16'h0000, 1'b0);
    wr_op(p, 5'h10, {1'b1, 4'h0, p, 6'h0}, 1'b1);
    wr_op(p, 5'h01, 16'h0040, 1'b1);
    exp_q.push_back(16'h0001);
    rd_val = {15'h0, skip_en};
    -> rd_done;
    rd_exp(p, 5'h10, {5'h0, p, 6'h0}, 1'b1);
    rd_exp(p, 5'h01, 16'h0040, 1'b1);
    $display("test 5 done");
    ahb(1'b0, 8'h0c, 32'h0, r);
    exp_q.push_back(16'h0000);
    rd_val = r[15:0];
    -> rd_done;
    freeze = 1'b1;
    rd_exp(p, 5'h04, 16'h1234, 1'b0);
    freeze = 1'b0;
    $display("test 6 done");
    repeat (4) @(posedge clk_sys);
    chk("pending writes", 32'h0, wexp_q.size());
    print_verdict();
  end
endmodule
`default_nettype wire

// >>> inc/pms_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pms_link_if;
  logic mgmt_clk;
  logic ctl_data_o;
  logic ctl_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic data_line;

  // Shared data wire with pull-up when nobody drives
  assign data_line = dev_data_oe ? dev_data_o : (ctl_data_oe ? ctl_data_o : 1'b1);

  modport dev(input mgmt_clk, input data_line, output dev_data_o, output dev_data_oe);
  modport ctl(output mgmt_clk, output ctl_data_o, output ctl_data_oe, input data_line);
endinterface
`default_nettype wire

// >>> inc/pms_pkg.sv
package pms_pkg;
  // Frame layout
  localparam int AW = 5;
  localparam int DW = 16;
  localparam int PRE_LEN = 32;
  localparam int HDR_LEN = 12;
  localparam int TA_LEN = 2;
  localparam int FRAME_LEN = 64;
  localparam logic [1:0] SFD_CODE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [15:0] DATA_ABSENT = 16'hffff;

  // Register map
  localparam logic [4:0] REG_STD_LAST = 5'h08;
  localparam logic [4:0] REG_VENDOR_FIRST = 5'h10;
  localparam logic [4:0] REG_VENDOR_LAST = 5'h13;
  localparam int NUM_REGS = 13;
  localparam logic [3:0] IDX_VENDOR_BASE = 4'h9;
  localparam int IDX_STATUS = 1;
  localparam int IDX_ID_HIGH = 2;
  localparam int IDX_ID_LOW = 3;
  localparam int IDX_EXT_CONTROL = 9;
  localparam int SKIP_BIT = 6;
  localparam int OVERRIDE_BIT = 15;
  localparam int PHYAD_LSB = 6;
  localparam int PHYAD_MSB = 10;

  // Controller registers on the AHB-Lite slave
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int CMD_REG_LSB = 0;
  localparam int CMD_PHY_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int CMD_SKIP_BIT = 17;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Timing
  localparam int SYS_PERIOD_NS = 4;
  localparam int MDC_PERIOD_NS = 80;
  localparam int MDC_HALF_CYC = MDC_PERIOD_NS / (2 * SYS_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_HUNT = 3'h0,
    ST_SFD = 3'h1,
    ST_HDR = 3'h3,
    ST_TURN = 3'h2,
    ST_DATA = 3'h6
  } pms_state_e;
endpackage

// >>> src/pms_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module pms_ctl
  import pms_pkg::*;
#(
  parameter int HALF_CYC = MDC_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  pms_link_if.ctl link
);
  logic a_valid_reg;
  logic a_write_reg;
  logic [7:0] a_addr_reg;
  logic [AW-1:0] phy_reg;
  logic [AW-1:0] sel_reg;
  logic write_reg;
  logic skip_reg;
  logic [DW-1:0] wdata_reg;
  logic [DW-1:0] rdata_reg;
  logic busy_reg;
  logic launch_reg;
  logic [7:0] div_reg;
  logic mdc_reg;
  logic [5:0] idx_reg;
  logic out_reg;
  logic oe_reg;
  logic [1:0] line_sync_reg;

  wire addr_phase = hsel & hready & htrans[1];
  wire wr_cmd = a_valid_reg & a_write_reg & (a_addr_reg == OFS_CMD) & ~busy_reg;
  wire wr_data = a_valid_reg & a_write_reg & (a_addr_reg == OFS_DATA) & ~busy_reg;
  wire [31:0] cmd_word = (32'(sel_reg) << CMD_REG_LSB) | (32'(phy_reg) << CMD_PHY_LSB)
    | (32'(write_reg) << CMD_WRITE_BIT) | (32'(skip_reg) << CMD_SKIP_BIT);
  wire [31:0] rd_mux = (haddr[7:0] == OFS_CMD) ? cmd_word
    : (haddr[7:0] == OFS_DATA) ? {16'h0, rdata_reg}
    : (haddr[7:0] == OFS_STATUS) ? {31'h0, busy_reg} : 32'h0;
  // Whole frame, preamble first: ones, delimiter, opcode, address, register, turnaround, data
  wire [FRAME_LEN-1:0] frame = {{PRE_LEN{1'b1}}, SFD_CODE, write_reg ? OP_WRITE : OP_READ,
    phy_reg, sel_reg, TA_WRITE, wdata_reg};
  wire tick = div_reg == 8'(HALF_CYC - 1);
  wire [5:0] idx_dec = idx_reg - 6'h1;
  wire [5:0] start_idx = skip_reg ? 6'(DW + TA_LEN + HDR_LEN + 1) : 6'(FRAME_LEN - 1);
  wire drives_next = write_reg | (idx_dec >= 6'(DW + TA_LEN));

  // AHB-Lite address phase capture and registered read data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      a_valid_reg <= 1'b0;
      a_write_reg <= 1'b0;
      a_addr_reg <= 8'h0;
      hrdata <= 32'h0;
    end else if (clk_en && hready) begin
      a_valid_reg <= addr_phase;
      a_write_reg <= hwrite;
      a_addr_reg <= haddr[7:0];
      if (addr_phase && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      line_sync_reg <= 2'h3;
    end else if (clk_en) begin
      line_sync_reg <= {line_sync_reg[0], link.data_line};
    end
  end

  // Command registers and frame engine
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phy_reg <= '0;
      sel_reg <= '0;
      write_reg <= 1'b0;
      skip_reg <= 1'b0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      busy_reg <= 1'b0;
      launch_reg <= 1'b0;
      div_reg <= 8'h0;
      mdc_reg <= 1'b0;
      idx_reg <= 6'h0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_data) begin
        wdata_reg <= hwdata[DW-1:0];
      end
      if (wr_cmd) begin
        sel_reg <= hwdata[CMD_REG_LSB +: AW];
        phy_reg <= hwdata[CMD_PHY_LSB +: AW];
        write_reg <= hwdata[CMD_WRITE_BIT];
        skip_reg <= hwdata[CMD_SKIP_BIT];
        busy_reg <= 1'b1;
        launch_reg <= 1'b1;
      end else if (launch_reg) begin
        launch_reg <= 1'b0;
        div_reg <= 8'h0;
        mdc_reg <= 1'b0;
        idx_reg <= start_idx;
        out_reg <= frame[start_idx];
        oe_reg <= 1'b1;
      end else if (busy_reg) begin
        div_reg <= tick ? 8'h0 : div_reg + 8'h1;
        if (tick) begin
          mdc_reg <= ~mdc_reg;
          if (!mdc_reg) begin
            if (!write_reg && idx_reg < 6'(DW)) begin
              rdata_reg <= {rdata_reg[DW-2:0], line_sync_reg[1]};
            end
          end else if (idx_reg == 6'h0) begin
            busy_reg <= 1'b0;
            oe_reg <= 1'b0;
            out_reg <= 1'b0;
          end else begin
            idx_reg <= idx_dec;
            out_reg <= frame[idx_dec];
            oe_reg <= drives_next;
          end
        end
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign link.mgmt_clk = mdc_reg;
  assign link.ctl_data_o = out_reg;
  assign link.ctl_data_oe = oe_reg;
endmodule
`default_nettype wire

// >>> src/pms_dev.sv
// What this block does
// - Frame carries five-bit device address field.
// - Respond only when address matches stored address.
// - Five-bit field selects one of 32 registers.
// - Read turnaround: float first bit, drive low.
// - Write turnaround: controller sends one then zero.
// - Data phase is exactly sixteen bits.
// - Read opcode 10 shifts selected register out.
// - Write opcode 01 loads sixteen bits.
// - Absent register reads return all ones.
// - Writes to absent registers are discarded.
// - Data moves most significant bit first.
// - Data output floats between transactions.
// - Accept back-to-back frames without idle bits.
// - Decode standard registers 0-8, 9-15 reserved.
// - Decode vendor registers 16-19, 20-31 reserved.
// - Without skip, need 32 ones before frame.
// - Start delimiter 01 then opcode follows.
// - Ignore opcodes 00 and 11.
// - Skip bit writable only after override set.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pms_dev
  import pms_pkg::*;
#(
  parameter logic [15:0] ID_HIGH = 16'h0123,  // Arbitrary identifier value
  parameter logic [15:0] ID_LOW = 16'h4560    // Arbitrary identifier value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  pms_link_if.dev link,
  input wire logic [AW-1:0] phy_addr_strap,
  output logic preamble_skip_enable,
  output logic wr_strobe,
  output logic [AW-1:0] wr_addr,
  output logic [DW-1:0] wr_data
);
  logic [2:0] clk_sync_reg;
  logic [1:0] dat_sync_reg;
  pms_state_e state_reg;
  logic [4:0] cnt_reg;
  logic [5:0] pre_cnt_reg;
  logic [HDR_LEN-1:0] hdr_reg;
  logic [DW-1:0] shift_reg;
  logic rd_reg;
  logic wr_reg;
  logic [3:0] widx_reg;
  logic [AW-1:0] waddr_reg;
  logic out_reg;
  logic oe_reg;
  logic [DW-1:0] regs [NUM_REGS];
  logic [AW-1:0] strap_meta_reg;
  logic [AW-1:0] strap_sync_reg;

  // Strap pins are asynchronous; only the second stage feeds the reset value
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      strap_meta_reg <= phy_addr_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Synchronise the link pins; index 0 feeds only index 1
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clk_sync_reg <= 3'h0;
      dat_sync_reg <= 2'h3;
    end else if (clk_en) begin
      clk_sync_reg <= {clk_sync_reg[1:0], link.mgmt_clk};
      dat_sync_reg <= {dat_sync_reg[0], link.data_line};
    end
  end

  wire mdc_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
  wire bit_in = dat_sync_reg[1];
  wire step = clk_en & mdc_rise;

  wire [HDR_LEN-1:0] hdr_full = {hdr_reg[HDR_LEN-2:0], bit_in};
  wire [1:0] hdr_op = hdr_full[HDR_LEN-1 -: 2];
  wire [AW-1:0] hdr_phy = hdr_full[2*AW-1 -: AW];
  wire [AW-1:0] hdr_reg_sel = hdr_full[AW-1:0];
  wire addr_hit = hdr_phy == regs[IDX_EXT_CONTROL][PHYAD_MSB:PHYAD_LSB];
  wire is_std = hdr_reg_sel <= REG_STD_LAST;
  wire is_vendor = hdr_reg_sel >= REG_VENDOR_FIRST && hdr_reg_sel <= REG_VENDOR_LAST;
  wire reg_exists = is_std | is_vendor;
  wire [3:0] reg_idx = is_std ? hdr_reg_sel[3:0] : hdr_reg_sel[3:0] + IDX_VENDOR_BASE;
  wire [DW-1:0] rd_val = reg_exists ? regs[reg_idx] : DATA_ABSENT;
  wire go_read = addr_hit & (hdr_op == OP_READ);
  wire go_write = addr_hit & (hdr_op == OP_WRITE) & reg_exists;
  wire pre_ok = (pre_cnt_reg == 6'(PRE_LEN)) | preamble_skip_enable;
  wire data_last = cnt_reg == 5'(DW - 1);
  wire [DW-1:0] wd_full = {shift_reg[DW-2:0], bit_in};
  wire commit = step & (state_reg == ST_DATA) & data_last & wr_reg;
  wire override = regs[IDX_EXT_CONTROL][OVERRIDE_BIT];
  wire [DW-1:0] skip_mask = DW'(1) << SKIP_BIT;
  wire [DW-1:0] ovr_mask = DW'(1) << OVERRIDE_BIT;
  wire [DW-1:0] ext_rst_val = DW'(strap_sync_reg) << PHYAD_LSB;

  // Frame decoder, one step per management clock rising edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_HUNT;
      cnt_reg <= 5'h0;
      pre_cnt_reg <= 6'h0;
      hdr_reg <= '0;
      shift_reg <= '0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      widx_reg <= 4'h0;
      waddr_reg <= '0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (step) begin
      unique case (state_reg)
        ST_HUNT: begin
          if (bit_in) begin
            if (pre_cnt_reg != 6'(PRE_LEN)) begin
              pre_cnt_reg <= pre_cnt_reg + 6'h1;
            end
          end else if (pre_ok) begin
            state_reg <= ST_SFD;
          end else begin
            pre_cnt_reg <= 6'h0;
          end
        end
        ST_SFD: begin
          pre_cnt_reg <= 6'h0;
          cnt_reg <= 5'h0;
          state_reg <= (bit_in == SFD_CODE[0]) ? ST_HDR : ST_HUNT;
        end
        ST_HDR: begin
          hdr_reg <= hdr_full;
          cnt_reg <= cnt_reg + 5'h1;
          if (cnt_reg == 5'(HDR_LEN - 1)) begin
            cnt_reg <= 5'h0;
            state_reg <= ST_TURN;
            rd_reg <= go_read;
            wr_reg <= go_write;
            shift_reg <= rd_val;
            widx_reg <= reg_idx;
            waddr_reg <= hdr_reg_sel;
          end
        end
        ST_TURN: begin
          cnt_reg <= cnt_reg + 5'h1;
          if (cnt_reg == 5'h0) begin
            oe_reg <= rd_reg;
            out_reg <= 1'b0;
          end else begin
            cnt_reg <= 5'h0;
            state_reg <= ST_DATA;
            out_reg <= shift_reg[DW-1];
            shift_reg <= {shift_reg[DW-2:0], 1'b0};
          end
        end
        ST_DATA: begin
          shift_reg <= wd_full;
          out_reg <= shift_reg[DW-1];
          cnt_reg <= cnt_reg + 5'h1;
          if (data_last) begin
            oe_reg <= 1'b0;
            out_reg <= 1'b0;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            cnt_reg <= 5'h0;
            state_reg <= ST_HUNT;
          end
        end
        default: state_reg <= ST_HUNT;
      endcase
    end
  end

  // Register storage, one entry per existing address
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_regs
      if (gi == IDX_ID_HIGH) begin : g_idh
        assign regs[gi] = ID_HIGH;
      end else if (gi == IDX_ID_LOW) begin : g_idl
        assign regs[gi] = ID_LOW;
      end else if (gi == IDX_STATUS) begin : g_stat
        // Only the skip bit is stored, and only under override
        always_ff @(posedge clk_sys) begin
          if (rst) begin
            regs[gi] <= '0;
          end else if (commit && widx_reg == 4'(gi) && override) begin
            regs[gi] <= wd_full & skip_mask;
          end
        end
      end else if (gi == IDX_EXT_CONTROL) begin : g_ext
        // Strapped address caught during reset; override clears on next write to any other register
        always_ff @(posedge clk_sys) begin
          if (rst) begin
            regs[gi] <= ext_rst_val;
          end else if (commit) begin
            regs[gi] <= (widx_reg == 4'(gi)) ? wd_full : (regs[gi] & ~ovr_mask);
          end
        end
      end else begin : g_rw
        always_ff @(posedge clk_sys) begin
          if (rst) begin
            regs[gi] <= '0;
          end else if (commit && widx_reg == 4'(gi)) begin
            regs[gi] <= wd_full;
          end
        end
      end
    end
  endgenerate

  // Write notice to the rest of the transceiver
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_strobe <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else if (clk_en) begin
      wr_strobe <= commit;
      if (commit) begin
        wr_addr <= waddr_reg;
        wr_data <= wd_full;
      end
    end
  end

  assign preamble_skip_enable = regs[IDX_STATUS][SKIP_BIT];
  assign link.dev_data_o = out_reg;
  assign link.dev_data_oe = oe_reg;
endmodule
`default_nettype wire
